// File: rtl/interrupt_vector_priority.v
// Interrupt flag, mask, priority and vector selection
`timescale 1ns/1ps
`include "intvec_defs.vh"
module interrupt_vector_priority (
    // Clock and reset
    input  wire               clk_sys,
    input  wire               sys_rst,
    // External user pins, active low, asynchronous
    input  wire               user_pin_zero_n,
    input  wire               user_pin_one_n,
    input  wire               user_pin_two_n,
    input  wire               user_pin_three_n,
    input  wire               nmi_pin_n,
    // On-chip peripheral requests, one-cycle pulses
    input  wire               timer_request,
    input  wire               port_zero_rx_request,
    input  wire               port_zero_tx_request,
    input  wire               port_one_rx_request,
    input  wire               port_one_tx_request,
    input  wire               port_two_rx_request,
    input  wire               port_two_tx_request,
    input  wire               host_port_request,
    input  wire               dma_ch_four_request,
    input  wire               dma_ch_five_request,
    // Core side controls
    input  wire               soft_reset_trap,
    input  wire               soft_trap_req,
    input  wire [`NUM_W-1:0]  soft_trap_num,
    input  wire [`VEC_W-1:0]  vec_base,
    input  wire               global_enable,
    input  wire               mask_wr,
    input  wire [`MASK_W-1:0] mask_wdata,
    input  wire               flag_clr,
    input  wire [`MASK_W-1:0] flag_clr_bits,
    input  wire               irq_ack,
    // Core side results
    output reg                irq_req_r,
    output reg  [`NUM_W-1:0]  irq_num_r,
    output reg  [`VEC_W-1:0]  irq_vec_r,
    output reg  [4:0]         irq_prio_r,
    output reg  [`MASK_W-1:0] pending_flag_register,
    output reg  [`MASK_W-1:0] enable_mask_register
);
    // Synchronised pin levels, high while asserted
    wire              pin0_lvl;
    wire              pin1_lvl;
    wire              pin2_lvl;
    wire              pin3_lvl;
    wire              nmi_lvl;
    reg  [4:0]        pin_prev_r;
    reg               nmi_pend_r;
    reg  [`MASK_W-1:0] event_vec;
    reg  [`MASK_W-1:0] flag_nxt;
    reg  [`MASK_W-1:0] active;
    reg               sel_valid;
    reg  [`NUM_W-1:0] sel_num;
    reg  [4:0]        sel_prio;
    reg  [`MASK_W-1:0] ack_bit;
    reg               ack_nmi;
    wire [`VEC_W-1:0] sel_addr;
    // Rising edges of the filtered pins, one cycle each
    wire              pin0_edge;
    wire              pin1_edge;
    wire              pin2_edge;
    wire              pin3_edge;
    wire              nmi_edge;
    wire              soft_ok;
    wire              hw_any;
    wire              load_en;

    // Pins pass four flops before their edges count
    pin_sync u_sync0 (.clk_sys(clk_sys), .sys_rst(sys_rst),
                      .pin_in(~user_pin_zero_n),  .level_r(pin0_lvl));
    pin_sync u_sync1 (.clk_sys(clk_sys), .sys_rst(sys_rst),
                      .pin_in(~user_pin_one_n),   .level_r(pin1_lvl));
    pin_sync u_sync2 (.clk_sys(clk_sys), .sys_rst(sys_rst),
                      .pin_in(~user_pin_two_n),   .level_r(pin2_lvl));
    pin_sync u_sync3 (.clk_sys(clk_sys), .sys_rst(sys_rst),
                      .pin_in(~user_pin_three_n), .level_r(pin3_lvl));
    pin_sync u_syncn (.clk_sys(clk_sys), .sys_rst(sys_rst),
                      .pin_in(~nmi_pin_n),        .level_r(nmi_lvl));

    // Edge history of the filtered pins
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_prev_r <= 5'h00;
        end else begin
            pin_prev_r <= {nmi_lvl, pin3_lvl, pin2_lvl, pin1_lvl, pin0_lvl};
        end
    end

    // A new asserted level counts once, on its first cycle
    assign pin0_edge = pin0_lvl & ~pin_prev_r[0];
    assign pin1_edge = pin1_lvl & ~pin_prev_r[1];
    assign pin2_edge = pin2_lvl & ~pin_prev_r[2];
    assign pin3_edge = pin3_lvl & ~pin_prev_r[3];
    assign nmi_edge  = nmi_lvl & ~pin_prev_r[4];

    always @* begin
        event_vec                = {`MASK_W{1'b0}};
        event_vec[`BIT_PIN0]     = pin0_edge;
        event_vec[`BIT_PIN1]     = pin1_edge;
        event_vec[`BIT_PIN2]     = pin2_edge;
        event_vec[`BIT_TIMER]    = timer_request;
        event_vec[`BIT_P0_RX]    = port_zero_rx_request;
        event_vec[`BIT_P0_TX]    = port_zero_tx_request;
        event_vec[`BIT_P2_RX]    = port_two_rx_request;
        event_vec[`BIT_P2_TX]    = port_two_tx_request;
        event_vec[`BIT_PIN3]     = pin3_edge;
        event_vec[`BIT_HOST]     = host_port_request;
        event_vec[`BIT_P1_RX]    = port_one_rx_request;
        event_vec[`BIT_P1_TX]    = port_one_tx_request;
        event_vec[`BIT_DMA4]     = dma_ch_four_request;
        event_vec[`BIT_DMA5]     = dma_ch_five_request;
    end

    // Acknowledge clears the flag of the request taken
    always @* begin
        ack_bit = {`MASK_W{1'b0}};
        ack_nmi = 1'b0;
        if (irq_ack && irq_req_r) begin
            if (irq_num_r == `TRAP_NMI) begin
                ack_nmi = 1'b1;
            // User pins and timer
            end else if (irq_num_r == `TRAP_PIN0) begin
                ack_bit[`BIT_PIN0] = 1'b1;
            end else if (irq_num_r == `TRAP_PIN1) begin
                ack_bit[`BIT_PIN1] = 1'b1;
            end else if (irq_num_r == `TRAP_PIN2) begin
                ack_bit[`BIT_PIN2] = 1'b1;
            end else if (irq_num_r == `TRAP_TIMER) begin
                ack_bit[`BIT_TIMER] = 1'b1;
            // Serial ports zero and two
            end else if (irq_num_r == `TRAP_P0_RX) begin
                ack_bit[`BIT_P0_RX] = 1'b1;
            end else if (irq_num_r == `TRAP_P0_TX) begin
                ack_bit[`BIT_P0_TX] = 1'b1;
            end else if (irq_num_r == `TRAP_P2_RX) begin
                ack_bit[`BIT_P2_RX] = 1'b1;
            end else if (irq_num_r == `TRAP_P2_TX) begin
                ack_bit[`BIT_P2_TX] = 1'b1;
            // Pin three and host port
            end else if (irq_num_r == `TRAP_PIN3) begin
                ack_bit[`BIT_PIN3] = 1'b1;
            end else if (irq_num_r == `TRAP_HOST) begin
                ack_bit[`BIT_HOST] = 1'b1;
            // Serial port one and DMA channels
            end else if (irq_num_r == `TRAP_P1_RX) begin
                ack_bit[`BIT_P1_RX] = 1'b1;
            end else if (irq_num_r == `TRAP_P1_TX) begin
                ack_bit[`BIT_P1_TX] = 1'b1;
            end else if (irq_num_r == `TRAP_DMA4) begin
                ack_bit[`BIT_DMA4] = 1'b1;
            end else if (irq_num_r == `TRAP_DMA5) begin
                ack_bit[`BIT_DMA5] = 1'b1;
            end
        end
    end

    // Flags: a new event wins over a clear in the same cycle
    always @* begin
        flag_nxt = pending_flag_register & ~ack_bit;
        if (flag_clr) begin
            flag_nxt = flag_nxt & ~flag_clr_bits;
        end
        flag_nxt = flag_nxt | event_vec;
    end

    // Flag register, updated every cycle
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pending_flag_register <= `FLAG_RST;
        end else begin
            pending_flag_register <= flag_nxt;
        end
    end

    // Mask register, written by the core
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            enable_mask_register <= `MASK_RST;
        end else if (mask_wr) begin
            enable_mask_register <= mask_wdata;
        end
    end

    // nonmaskable latch, a new edge beats the acknowledge
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            nmi_pend_r <= 1'b0;
        end else if (nmi_edge) begin
            nmi_pend_r <= 1'b1;
        end else if (ack_nmi) begin
            nmi_pend_r <= 1'b0;
        end
    end

    // Any enabled hardware request while the gate is open
    assign hw_any  = global_enable && (|(pending_flag_register & enable_mask_register));
    assign soft_ok = soft_trap_req && (soft_trap_num <= `TRAP_LIMIT);

    always @* begin
        active    = pending_flag_register & enable_mask_register;
        sel_valid = 1'b0;
        sel_num   = `TRAP_RESET;
        sel_prio  = 5'h00;
        if (soft_reset_trap) begin
            sel_valid = 1'b1;
            sel_num   = `TRAP_RESET;
            sel_prio  = 5'h01;
        end else if (nmi_pend_r) begin
            sel_valid = 1'b1;
            sel_num   = `TRAP_NMI;
            sel_prio  = 5'h02;
        end else if (hw_any) begin
            sel_valid = 1'b1;
            if (active[`BIT_PIN0]) begin
                sel_num  = `TRAP_PIN0;
                sel_prio = 5'h03;
            end else if (active[`BIT_PIN1]) begin
                sel_num  = `TRAP_PIN1;
                sel_prio = 5'h04;
            end else if (active[`BIT_PIN2]) begin
                sel_num  = `TRAP_PIN2;
                sel_prio = 5'h05;
            end else if (active[`BIT_TIMER]) begin
                sel_num  = `TRAP_TIMER;
                sel_prio = 5'h06;
            end else if (active[`BIT_P0_RX]) begin
                sel_num  = `TRAP_P0_RX;
                sel_prio = 5'h07;
            end else if (active[`BIT_P0_TX]) begin
                sel_num  = `TRAP_P0_TX;
                sel_prio = 5'h08;
            end else if (active[`BIT_P2_RX]) begin
                sel_num  = `TRAP_P2_RX;
                sel_prio = 5'h09;
            end else if (active[`BIT_P2_TX]) begin
                sel_num  = `TRAP_P2_TX;
                sel_prio = 5'h0a;
            end else if (active[`BIT_PIN3]) begin
                sel_num  = `TRAP_PIN3;
                sel_prio = 5'h0b;
            end else if (active[`BIT_HOST]) begin
                sel_num  = `TRAP_HOST;
                sel_prio = 5'h0c;
            end else if (active[`BIT_P1_RX]) begin
                sel_num  = `TRAP_P1_RX;
                sel_prio = 5'h0d;
            end else if (active[`BIT_P1_TX]) begin
                sel_num  = `TRAP_P1_TX;
                sel_prio = 5'h0e;
            end else if (active[`BIT_DMA4]) begin
                sel_num  = `TRAP_DMA4;
                sel_prio = 5'h0f;
            end else if (active[`BIT_DMA5]) begin
                sel_num  = `TRAP_DMA5;
                sel_prio = 5'h10;
            end
        end else if (soft_ok) begin
            sel_valid = 1'b1;
            sel_num   = soft_trap_num;
            sel_prio  = 5'h00;
        end
    end

    vec_addr u_vec (.vec_base(vec_base), .trap_num(sel_num), .vec_addr_out(sel_addr));

    // A new selection loads when idle or on an acknowledge
    assign load_en = !irq_req_r || irq_ack;

    // Registered request towards the core; held until acknowledged
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_req_r <= 1'b1;
        end else if (load_en) begin
            irq_req_r <= sel_valid & ~irq_ack;
        end
    end

    // Number, vector and priority travel with the request
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_num_r  <= `TRAP_RESET;
            irq_vec_r  <= {`VEC_W{1'b0}};
            irq_prio_r <= 5'h01;
        end else if (load_en) begin
            irq_num_r  <= sel_num;
            irq_vec_r  <= sel_addr;
            irq_prio_r <= sel_prio;
        end
    end
endmodule // interrupt_vector_priority

// File: rtl/intvec_defs.vh
// Constants for the interrupt vector and priority block
`ifndef INTVEC_DEFS_VH
`define INTVEC_DEFS_VH
`define NUM_W          5
`define VEC_W          16
`define MASK_W         14
`define VEC_STEP_SHIFT 2
`define TRAP_RESET     5'h00
`define TRAP_NMI       5'h01
`define TRAP_SOFT_LO   5'h02
`define TRAP_SOFT_HI   5'h0f
`define TRAP_PIN0      5'h10
`define TRAP_PIN1      5'h11
`define TRAP_PIN2      5'h12
`define TRAP_TIMER     5'h13
`define TRAP_P0_RX     5'h14
`define TRAP_P0_TX     5'h15
`define TRAP_P2_RX     5'h16
`define TRAP_P2_TX     5'h17
`define TRAP_PIN3      5'h18
`define TRAP_HOST      5'h19
`define TRAP_P1_RX     5'h1a
`define TRAP_P1_TX     5'h1b
`define TRAP_DMA4      5'h1c
`define TRAP_DMA5      5'h1d
`define TRAP_LIMIT     5'h1d
`define BIT_PIN0       0
`define BIT_PIN1       1
`define BIT_PIN2       2
`define BIT_TIMER      3
`define BIT_P0_RX      4
`define BIT_P0_TX      5
`define BIT_P2_RX      6
`define BIT_P2_TX      7
`define BIT_PIN3       8
`define BIT_HOST       9
`define BIT_P1_RX      10
`define BIT_P1_TX      11
`define BIT_DMA4       12
`define BIT_DMA5       13
`define FLAG_RST       14'h0000
`define MASK_RST       14'h0000
`endif

// File: rtl/pin_sync.v
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input  wire clk_sys,
    input  wire sys_rst,
    // Pin and filtered level
    input  wire pin_in,
    output reg  level_r
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    // Level changes once stages two and three agree
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end
endmodule // pin_sync

// File: rtl/vec_addr.v
// Vector address from base and trap number
`timescale 1ns/1ps
`include "intvec_defs.vh"
module vec_addr (
    // Base and number
    input  wire [`VEC_W-1:0] vec_base,
    input  wire [`NUM_W-1:0] trap_num,
    // Resulting address
    output wire [`VEC_W-1:0] vec_addr_out
);
    wire [`VEC_W-1:0] offset;

    assign offset       = {{(`VEC_W-`NUM_W-`VEC_STEP_SHIFT){1'b0}}, trap_num, 2'b00};
    assign vec_addr_out = vec_base + offset;
endmodule // vec_addr

// File: verification/intvec_checker.sv
// Checker for the interrupt vector and priority outputs
`timescale 1ns/1ps
`include "intvec_defs.vh"
module intvec_checker (
    // Clock and reset
    input wire               clk_sys,
    input wire               sys_rst,
    // Watched inputs
    input wire               timer_request,
    input wire               dma_ch_five_request,
    input wire               irq_ack,
    input wire [`VEC_W-1:0]  vec_base,
    // Watched outputs
    input wire               irq_req_r,
    input wire [`NUM_W-1:0]  irq_num_r,
    input wire [`VEC_W-1:0]  irq_vec_r,
    input wire [4:0]         irq_prio_r,
    input wire [`MASK_W-1:0] pending_flag_register
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Core takes the request, or leaves it waiting
    sequence s_grant; irq_req_r && irq_ack; endsequence
    sequence s_wait; irq_req_r && !irq_ack; endsequence
    a_vec_offset: assert property ($rose(irq_req_r) |->
        irq_vec_r == vec_base + {irq_num_r, 2'b00}) else $error("vector offset wrong");
    a_fixed_prio: assert property (irq_req_r && irq_num_r < 5'h02 |->
        irq_prio_r == irq_num_r + 5'h01) else $error("reset or nmi priority wrong");
    a_soft_noprio: assert property (irq_req_r && irq_num_r inside {[2:15]} |->
        irq_prio_r == 5'h00) else $error("software trap has a priority");
    a_hw_prio: assert property (irq_req_r && irq_num_r >= 5'h10 |->
        irq_prio_r == irq_num_r - 5'h0d) else $error("hardware priority wrong");
    a_num_limit: assert property (irq_req_r |-> irq_num_r <= `TRAP_LIMIT)
        else $error("reserved number generated");
    a_timer_flag: assert property (timer_request |=> pending_flag_register[`BIT_TIMER])
        else $error("timer flag not set");
    a_dma5_flag: assert property (dma_ch_five_request |=> pending_flag_register[`BIT_DMA5])
        else $error("dma five flag not set");
    a_hold_req: assert property (s_wait |=> irq_req_r && $stable(irq_num_r))
        else $error("request dropped before ack");
    a_ack_drop: assert property (s_grant |=> !irq_req_r)
        else $error("request stays after ack");
endmodule // intvec_checker

bind interrupt_vector_priority intvec_checker u_chk (
    .clk_sys, .sys_rst, .timer_request, .dma_ch_five_request, .irq_ack, .vec_base,
    .irq_req_r, .irq_num_r, .irq_vec_r, .irq_prio_r, .pending_flag_register);

// File: verification/core_ack_model.sv
// Core model that acknowledges a request after a chosen wait
`timescale 1ns/1ps
module core_ack_model (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       sys_rst,
    // Request and pacing
    input  wire       irq_req_r,
    input  wire       ack_en,
    input  wire [3:0] ack_wait,
    output reg        irq_ack
);
    reg [3:0] cnt_r;
    // Count waiting cycles, then pulse the acknowledge once
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_ack <= 1'b0;
            cnt_r   <= 4'h0;
        end else if (irq_ack || !irq_req_r || !ack_en) begin
            irq_ack <= #1 1'b0;
            cnt_r   <= #1 4'h0;
        end else if (cnt_r >= ack_wait) begin
            irq_ack <= #1 1'b1;
        end else begin
            cnt_r <= #1 cnt_r + 4'h1;
        end
    end
endmodule // core_ack_model

// File: verification/tb_interrupt_vector_priority.sv
// Testbench for the interrupt vector and priority block
`timescale 1ns/1ps
module tb_interrupt_vector_priority;
    reg         clk_sys, sys_rst, nmi_n, soft_reset_trap, soft_trap_req;
    reg         global_enable, mask_wr, flag_clr, ack_en;
    reg  [3:0]  ack_wait;
    reg  [4:0]  soft_trap_num;
    reg  [13:0] src, mask_wdata, flag_clr_bits;
    reg  [15:0] vec_base;
    integer     errors, check_count, cycles, i;
    wire        irq_ack, irq_req_r;
    wire [4:0]  irq_num_r, irq_prio_r;
    wire [13:0] pending_flag_register, enable_mask_register;
    wire [15:0] irq_vec_r;
    interrupt_vector_priority DUT (.clk_sys, .sys_rst, .user_pin_zero_n(~src[0]),
        .user_pin_one_n(~src[1]), .user_pin_two_n(~src[2]), .user_pin_three_n(~src[8]),
        .nmi_pin_n(nmi_n), .timer_request(src[3]), .port_zero_rx_request(src[4]),
        .port_zero_tx_request(src[5]), .port_two_rx_request(src[6]),
        .port_two_tx_request(src[7]), .host_port_request(src[9]),
        .port_one_rx_request(src[10]), .port_one_tx_request(src[11]),
        .dma_ch_four_request(src[12]), .dma_ch_five_request(src[13]), .soft_reset_trap,
        .soft_trap_req, .soft_trap_num, .vec_base, .global_enable, .mask_wr, .mask_wdata,
        .flag_clr, .flag_clr_bits, .irq_ack, .irq_req_r, .irq_num_r, .irq_vec_r,
        .irq_prio_r, .pending_flag_register, .enable_mask_register);
    core_ack_model u_core (.clk_sys, .sys_rst, .irq_req_r, .ack_en, .ack_wait, .irq_ack);
    // Clock and cycle ceiling
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            errors = errors + 1;
            results;
        end
    end
    task tick; begin @(posedge clk_sys); #1; end endtask
    task chk(input [15:0] seen, input [15:0] exp, input [8*8-1:0] what);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", check_count, errors);
            if (errors == 0 && check_count > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // Wait for a request, judge it, then let the core take it
    task expect_irq(input [4:0] num, input [4:0] prio);
        integer n;
        begin
            n = 0;
            while (irq_req_r !== 1'b1 && n < 30) begin tick; n = n + 1; end
            chk(irq_req_r, 1'b1, "req");
            chk(irq_num_r, num, "num");
            chk(irq_vec_r, vec_base + {num, 2'b00}, "vector");
            chk(irq_prio_r, prio, "prio");
            while (irq_req_r !== 1'b0 && n < 60) begin tick; n = n + 1; end
            chk(irq_req_r, 1'b0, "taken");
        end
    endtask
    task set_mask(input [13:0] m);
        begin
            mask_wr = 1'b1;
            mask_wdata = m;
            tick;
            mask_wr = 1'b0;
            chk(enable_mask_register, m, "mask");
        end
    endtask
    // Every hardware source alone, pins held until taken
    task t_table;
        for (i = 0; i < 14; i = i + 1) begin
            ack_wait = i[3:0];
            src = 14'h0001 << i;
            tick;
            src = src & 14'h0107;
            expect_irq(i[4:0] + 5'h10, i[4:0] + 5'h03);
            src = 14'h0000;
            repeat (6) tick;
        end
    endtask
    // Three at once come out in priority order
    task t_order;
        begin
            ack_en = 1'b0;
            src = 14'h2018;
            tick;
            src = 14'h0000;
            repeat (3) tick;
            chk(pending_flag_register, 14'h2018, "flags");
            ack_en = 1'b1;
            expect_irq(5'h13, 5'h06);
            expect_irq(5'h14, 5'h07);
            expect_irq(5'h1d, 5'h10);
        end
    endtask
    // Masked, gated and cleared requests stay quiet
    task t_refuse;
        begin
            set_mask(14'h3ff7);
            src[3] = 1'b1;
            tick;
            src = 14'h0000;
            repeat (4) tick;
            chk({irq_req_r, pending_flag_register[3]}, 16'h0001, "masked");
            global_enable = 1'b0;
            set_mask(14'h3fff);
            repeat (4) tick;
            chk(irq_req_r, 1'b0, "gated");
            flag_clr = 1'b1;
            flag_clr_bits = 14'h0008;
            tick;
            flag_clr = 1'b0;
            tick;
            chk(pending_flag_register, 14'h0000, "cleared");
            global_enable = 1'b1;
        end
    endtask
    // Software traps, the reserved number, nmi and soft reset
    task t_soft;
        begin
            for (i = 2; i < 16; i = i + 1) begin
                soft_trap_num = i[4:0];
                soft_trap_req = 1'b1;
                tick;
                soft_trap_req = 1'b0;
                expect_irq(i[4:0], 5'h00);
            end
            soft_trap_num = 5'h1e;
            soft_trap_req = 1'b1;
            tick;
            soft_trap_req = 1'b0;
            repeat (5) tick;
            chk(irq_req_r, 1'b0, "trap 30");
            nmi_n = 1'b0;
            expect_irq(5'h01, 5'h02);
            nmi_n = 1'b1;
            repeat (6) tick;
            soft_reset_trap = 1'b1;
            tick;
            soft_reset_trap = 1'b0;
            expect_irq(5'h00, 5'h01);
        end
    endtask
    initial begin
        {sys_rst, nmi_n, soft_reset_trap, soft_trap_req} = 4'hc;
        {global_enable, mask_wr, flag_clr, ack_en} = 4'h9;
        {src, mask_wdata, flag_clr_bits} = 42'h0;
        {vec_base, ack_wait, soft_trap_num} = 25'h0000020;
        {errors, check_count, cycles} = 96'h0;
        repeat (16) tick;
        chk({irq_req_r, irq_num_r, irq_prio_r}, 16'h0401, "reset");
        chk(pending_flag_register | enable_mask_register, 16'h0000, "regs");
        sys_rst = 1'b0;
        expect_irq(5'h00, 5'h01);
        vec_base = 16'h1200;
        set_mask(14'h3fff);
        t_table;
        t_order;
        t_refuse;
        t_soft;
        results;
    end
endmodule // tb_interrupt_vector_priority
